// ### hw/scia_pkg.sv
package scia_pkg;

    // Cyclic assembly sizes in bytes.
    localparam int unsigned OUT_ASM_BYTES = 4;
    localparam int unsigned IN_ASM_BYTES  = 12;

    // Addressing of the two assemblies.
    localparam logic [7:0] ASM_CLASS     = 8'h04;
    localparam logic [7:0] ASM_OUT_INST  = 8'h64;
    localparam logic [7:0] ASM_IN_INST   = 8'h65;
    localparam logic [7:0] ASM_ATTR      = 8'h03;

    // Byte offsets inside the assemblies.
    localparam logic [3:0] OFS_COMMAND   = 4'h0;
    localparam logic [3:0] OFS_CMD_SPARE = 4'h2;
    localparam logic [3:0] OFS_STATUS    = 4'h0;
    localparam logic [3:0] OFS_STAT_SPARE = 4'h2;
    localparam logic [3:0] OFS_CURRENT   = 4'h4;
    localparam logic [3:0] OFS_TRIP      = 4'h8;
    localparam logic [3:0] OFS_TAIL_SPARE = 4'hA;

    // Field positions in command_word.
    localparam int unsigned CMD_RUN_BIT   = 6;
    localparam int unsigned CMD_RESET_BIT = 7;
    localparam int unsigned CMD_MSET_BIT  = 13;

    // Field positions in starter_status_word.
    localparam int unsigned ST_READY_BIT   = 0;
    localparam int unsigned ST_OPMODE_BIT  = 1;
    localparam int unsigned ST_RUNNING_BIT = 2;
    localparam int unsigned ST_TRIP_BIT    = 3;
    localparam int unsigned ST_JOGF_BIT    = 4;
    localparam int unsigned ST_JOGR_BIT    = 5;
    localparam int unsigned ST_WARN_BIT    = 7;
    localparam int unsigned ST_FULLV_BIT   = 8;
    localparam int unsigned ST_NETSRC_BIT  = 9;
    localparam int unsigned ST_THERM_BIT   = 15;

    // Reset values.
    localparam logic [31:0] OUT_ASM_RESET = 32'h0000_0000;
    localparam logic [15:0] WORD_RESET    = 16'h0000;
    localparam logic [31:0] LONG_RESET    = 32'h0000_0000;
    localparam logic [7:0]  BYTE_ZERO     = 8'h00;

    // Timing of the cyclic exchange.
    localparam int unsigned SYS_CLK_HZ       = 10_000_000;
    localparam int unsigned MIN_INTERVAL_US  = 1000;
    localparam int unsigned MIN_INTERVAL_CYC = MIN_INTERVAL_US * (SYS_CLK_HZ / 1_000_000);

    typedef struct packed {
        logic       valid;
        logic       wr;
        logic [7:0] cls;
        logic [7:0] inst;
        logic [7:0] attr;
        logic [3:0] idx;
        logic [7:0] wdata;
    } scia_req_s;

    typedef struct packed {
        logic       valid;
        logic       err;
        logic [7:0] rdata;
    } scia_ans_s;

    typedef struct packed {
        logic        ready;
        logic        op_mode;
        logic        active;
        logic        tripped;
        logic        jog_fwd;
        logic        jog_rev;
        logic        warning;
        logic        full_volt;
        logic        over_thermal;
        logic [31:0] current;
        logic [15:0] trip_code;
    } scia_starter_s;

    typedef struct packed {
        logic run;
        logic trip_reset;
        logic motor_set;
        logic net_enabled;
    } scia_ctl_s;

endpackage

// ### hw/scia_interval_mon.sv
`timescale 1ns/1ps
module scia_interval_mon
    import scia_pkg::*;
#(
    parameter int unsigned MIN_CYC = MIN_INTERVAL_CYC,
    parameter int unsigned CNT_W   = 16
) (
    input  wire logic sys_clk,
    input  wire logic rst_b,
    input  wire logic commit,
    output logic      too_soon
);

    typedef struct packed {
        logic             seen;
        logic [CNT_W-1:0] cnt;
    } scia_mon_s;

    localparam logic [CNT_W-1:0] CNT_LIMIT = CNT_W'(MIN_CYC - 1);
    localparam logic [CNT_W-1:0] CNT_ONE   = CNT_W'(1);

    scia_mon_s mon_r;
    scia_mon_s mon_nxt;

    // Counting saturates so a long idle gap never wraps into a false alarm.
    always_comb begin
        mon_nxt  = mon_r;
        too_soon = commit && mon_r.seen && (mon_r.cnt < CNT_LIMIT);
        if (commit) begin
            mon_nxt.seen = 1'b1;
            mon_nxt.cnt  = '0;
        end else if (mon_r.cnt < CNT_LIMIT) begin
            mon_nxt.cnt = mon_r.cnt + CNT_ONE;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            mon_r <= '0;
        end else begin
            mon_r <= mon_nxt;
        end
    end

endmodule

// ### hw/scia_adapter.sv
// How it works
// - Only a 4-byte output assembly and a 12-byte input assembly exist.
// - Multi-byte fields travel least significant byte first.
// - Run bit one issues a start command to the starter.
// - Run bit zero issues a stop, whatever the top bit holds.
// - Trip reset only on a zero-to-one change of the reset bit.
// - A first byte of C0h gives trip reset and start together.
// - Motor set bit picks primary or secondary set, taken at next start.
// - Status bits 2,3,4,5,7 show active, tripped, jog directions, warning.
// - Status bit 8 shows full voltage, bit 9 shows network command source.
// - Status bit 15 shows motor above thermal capacity.
// - Input bytes 4 to 7 carry average current in 0.01 A units.
// - Input bytes 8 and 9 carry the 16-bit trip code.
// - Written output data is held until overwritten or reset.
// - A held command is resent when network control resumes.
// - The adapter is a managed I/O adapter serving one scanner.
// - Commands reach the starter only when the network is the command source.
`timescale 1ns/1ps
module scia_adapter
    import scia_pkg::*;
#(
    parameter int unsigned MIN_CYC = MIN_INTERVAL_CYC,
    parameter int unsigned MON_W   = 16
) (
    input  wire logic          sys_clk,
    input  wire logic          rst_b,
    input  wire scia_req_s     req,
    input  wire logic          commit,
    input  wire scia_starter_s starter,
    input  wire logic          cmd_src_network,
    input  wire logic          override_active,
    input  wire logic          disable_active,
    output scia_ans_s          ans,
    output scia_ctl_s          ctl,
    output logic               interval_fault
);

    typedef struct packed {
        logic [31:0] out_buf;
        logic [15:0] cmd_applied;
        logic        prev_reset;
        logic [15:0] snap_status;
        logic [31:0] snap_current;
        logic [15:0] snap_trip;
        scia_ans_s   ans;
        scia_ctl_s   ctl;
        logic        interval_fault;
    } scia_state_s;

    scia_state_s st_r;
    scia_state_s st_nxt;

    logic        too_soon;
    logic [15:0] live_status;
    logic        net_gate;
    logic        out_hit;
    logic        in_hit;

    // Replaces one byte of a 32-bit little-endian word.
    function automatic logic [31:0] put_byte(input logic [31:0] word,
                                             input logic [1:0]  pos,
                                             input logic [7:0]  data);
        logic [31:0] res;
        res = word;
        case (pos)
            2'h0: res[7:0]   = data;
            2'h1: res[15:8]  = data;
            2'h2: res[23:16] = data;
            2'h3: res[31:24] = data;
            default: res = word;
        endcase
        return res;
    endfunction

    // Picks one byte of the input assembly; spare bytes read zero.
    function automatic logic [7:0] in_byte(input logic [3:0]  idx,
                                           input logic [15:0] status,
                                           input logic [31:0] current,
                                           input logic [15:0] trip);
        logic [7:0] res;
        res = BYTE_ZERO;
        case (idx)
            OFS_STATUS:          res = status[7:0];
            OFS_STATUS + 4'h1:   res = status[15:8];
            OFS_CURRENT:         res = current[7:0];
            OFS_CURRENT + 4'h1:  res = current[15:8];
            OFS_CURRENT + 4'h2:  res = current[23:16];
            OFS_CURRENT + 4'h3:  res = current[31:24];
            OFS_TRIP:            res = trip[7:0];
            OFS_TRIP + 4'h1:     res = trip[15:8];
            default:             res = BYTE_ZERO;
        endcase
        return res;
    endfunction

    // check: flags a scanner that commits exchanges too close together.
    scia_interval_mon #(
        .MIN_CYC (MIN_CYC),
        .CNT_W   (MON_W)
    ) u_interval_mon (
        .sys_clk  (sys_clk),
        .rst_b    (rst_b),
        .commit   (commit),
        .too_soon (too_soon)
    );

    // activity, trip, jog and warning bits.
    always_comb begin
        live_status                 = WORD_RESET;
        live_status[ST_READY_BIT]   = starter.ready;
        live_status[ST_OPMODE_BIT]  = starter.op_mode;
        live_status[ST_RUNNING_BIT] = starter.active;
        live_status[ST_TRIP_BIT]    = starter.tripped;
        live_status[ST_JOGF_BIT]    = starter.jog_fwd;
        live_status[ST_JOGR_BIT]    = starter.jog_rev;
        live_status[ST_WARN_BIT]    = starter.warning;
        live_status[ST_FULLV_BIT]   = starter.full_volt;
        live_status[ST_NETSRC_BIT]  = cmd_src_network;
        live_status[ST_THERM_BIT]   = starter.over_thermal;
    end

    // network gate.
    // The gate also drops while overridden or disabled, so a held command
    // resumes on its own once control returns.
    assign net_gate = cmd_src_network && !override_active && !disable_active;

    assign out_hit = req.valid && req.wr && (req.cls == ASM_CLASS)
                     && (req.inst == ASM_OUT_INST) && (req.attr == ASM_ATTR)
                     && (req.idx < 4'(OUT_ASM_BYTES));

    assign in_hit = req.valid && !req.wr && (req.cls == ASM_CLASS)
                    && (req.inst == ASM_IN_INST) && (req.attr == ASM_ATTR)
                    && (req.idx < 4'(IN_ASM_BYTES));

    always_comb begin
        st_nxt                = st_r;
        st_nxt.ans.valid      = req.valid;
        st_nxt.ans.err        = req.valid && !out_hit && !in_hit;
        st_nxt.ans.rdata      = BYTE_ZERO;
        st_nxt.ctl.trip_reset = 1'b0;

        if (out_hit) begin
            st_nxt.out_buf = put_byte(st_r.out_buf, req.idx[1:0], req.wdata);
        end

        // status read out little-endian from the last snapshot.
        if (in_hit) begin
            st_nxt.ans.rdata = in_byte(req.idx, st_r.snap_status,
                                       st_r.snap_current, st_r.snap_trip);
        end

        // A commit closes one exchange: the command takes effect and the
        // status is frozen so multi-byte fields read back consistent.
        if (commit) begin
            st_nxt.cmd_applied = st_r.out_buf[15:0];
            st_nxt.prev_reset  = st_r.out_buf[CMD_RESET_BIT];
            st_nxt.snap_current = starter.current;
            st_nxt.snap_trip    = starter.trip_code;
            st_nxt.snap_status  = live_status;
            if (net_gate && st_r.out_buf[CMD_RESET_BIT] && !st_r.prev_reset) begin
                st_nxt.ctl.trip_reset = 1'b1;
            end
        end

        st_nxt.ctl.run         = net_gate && st_nxt.cmd_applied[CMD_RUN_BIT];
        st_nxt.ctl.net_enabled = net_gate;

        if (st_nxt.ctl.run && !st_r.ctl.run) begin
            st_nxt.ctl.motor_set = st_nxt.cmd_applied[CMD_MSET_BIT];
        end

        // Sticky until reset; a misbehaving scanner must stay visible.
        if (too_soon) begin
            st_nxt.interval_fault = 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            st_r.out_buf        <= OUT_ASM_RESET;
            st_r.cmd_applied    <= WORD_RESET;
            st_r.prev_reset     <= 1'b0;
            st_r.snap_status    <= WORD_RESET;
            st_r.snap_current   <= LONG_RESET;
            st_r.snap_trip      <= WORD_RESET;
            st_r.ans            <= '0;
            st_r.ctl            <= '0;
            st_r.interval_fault <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign ans            = st_r.ans;
    assign ctl            = st_r.ctl;
    assign interval_fault = st_r.interval_fault;

endmodule

// ### bench/scia_adapter_props.sv
`timescale 1ns/1ps
module scia_adapter_props
    import scia_pkg::*;
#(
    parameter int unsigned MIN_CYC = MIN_INTERVAL_CYC,
    parameter int unsigned MON_W   = 16
) (
    input wire logic          sys_clk,
    input wire logic          rst_b,
    input wire scia_req_s     req,
    input wire logic          commit,
    input wire scia_starter_s starter,
    input wire logic          cmd_src_network,
    input wire logic          override_active,
    input wire logic          disable_active,
    input wire scia_ans_s     ans,
    input wire scia_ctl_s     ctl,
    input wire logic          interval_fault
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_b);

    chk_ans_every_req: assert property (req.valid |=> ans.valid)
        else $error("request got no answer");
    chk_ans_has_cause: assert property (ans.valid |-> $past(req.valid))
        else $error("answer without request");
    chk_bad_class: assert property (req.valid && req.cls != ASM_CLASS |=> ans.err)
        else $error("foreign class accepted");
    chk_read_inst: assert property (req.valid && !req.wr && req.inst != ASM_IN_INST |=> ans.err)
        else $error("read of wrong instance accepted");
    chk_wr_range: assert property (req.valid && req.wr && req.idx >= 4'h4 |=> ans.err)
        else $error("write beyond four bytes accepted");
    chk_rd_range: assert property (req.valid && !req.wr && req.idx >= 4'hC |=> ans.err)
        else $error("read beyond twelve bytes accepted");
    chk_err_no_data: assert property (ans.err |-> ans.valid && ans.rdata == BYTE_ZERO)
        else $error("refused answer carries data");
    chk_reset_pulse: assert property (ctl.trip_reset |-> $past(commit) ##1 !ctl.trip_reset)
        else $error("trip reset pulse malformed");
    chk_run_gate: assert property ((!cmd_src_network || override_active || disable_active)
        |=> !ctl.run)
        else $error("run passed while network control off");
    chk_fault_sticky: assert property (interval_fault |=> interval_fault)
        else $error("interval fault dropped");
endmodule

bind scia_adapter scia_adapter_props #(.MIN_CYC(MIN_CYC), .MON_W(MON_W)) i_scia_adapter_props (
    .sys_clk(sys_clk), .rst_b(rst_b), .req(req), .commit(commit), .starter(starter),
    .cmd_src_network(cmd_src_network), .override_active(override_active),
    .disable_active(disable_active), .ans(ans), .ctl(ctl), .interval_fault(interval_fault));

// ### bench/scia_scanner_model.sv
`timescale 1ns/1ps
module scia_scanner_model
    import scia_pkg::*;
(
    input  wire logic      sys_clk,
    input  wire scia_ans_s ans,
    output scia_req_s      req,
    output logic           commit
);
    initial begin
        req = '0;
        commit = 1'h0;
    end
    // The request is held over exactly one taking edge, then dropped to zero.
    task automatic xfer(input logic wr, input logic [7:0] cls, input logic [7:0] inst,
                        input logic [3:0] idx, input logic [7:0] wd, output scia_ans_s got);
        @(posedge sys_clk);
        #1;
        req = '{1'h1, wr, cls, inst, ASM_ATTR, idx, wd};
        @(posedge sys_clk);
        #1;
        req = '0;
        got = ans;
    endtask
    task automatic wr_out(input logic [3:0] idx, input logic [7:0] wd, output scia_ans_s got);
        xfer(1'h1, ASM_CLASS, ASM_OUT_INST, idx, wd, got);
    endtask
    task automatic rd_in(input logic [3:0] idx, output scia_ans_s got);
        xfer(1'h0, ASM_CLASS, ASM_IN_INST, idx, 8'h00, got);
    endtask
    task automatic clear_spare();
        scia_ans_s got;
        wr_out(4'h2, 8'h00, got);
        wr_out(4'h3, 8'h00, got);
    endtask
    task automatic do_commit(input int gap);
        repeat (gap) @(posedge sys_clk);
        #1;
        commit = 1'h1;
        @(posedge sys_clk);
        #1;
        commit = 1'h0;
    endtask
endmodule

// ### bench/scia_adapter_tb.sv
`timescale 1ns/1ps
module scia_adapter_tb
    import scia_pkg::*;
;
    localparam int unsigned LIM = 20;
    logic          sys_clk = 1'h0;
    logic          rst_b = 1'h0;
    scia_req_s     req;
    logic          commit;
    scia_ans_s     ans;
    scia_ctl_s     ctl;
    scia_starter_s starter = '0;
    logic          cmd_src_network = 1'h1;
    logic          override_active = 1'h0;
    logic          disable_active = 1'h0;
    logic          interval_fault;
    scia_ans_s     got;
    int            n_fail = 0;
    int            check_count = 0;

    scia_adapter #(.MIN_CYC(LIM), .MON_W(16)) i_scia_adapter (
        .sys_clk(sys_clk), .rst_b(rst_b), .req(req), .commit(commit), .starter(starter),
        .cmd_src_network(cmd_src_network), .override_active(override_active),
        .disable_active(disable_active), .ans(ans), .ctl(ctl), .interval_fault(interval_fault));
    scia_scanner_model i_scia_scanner_model (
        .sys_clk(sys_clk), .ans(ans), .req(req), .commit(commit));

    always #50 sys_clk = ~sys_clk;

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [3:0] i, input logic [7:0] d);
        i_scia_scanner_model.wr_out(i, d, got);
        check("write answer", {got.valid, got.err}, 32'h2);
    endtask
    task automatic cmt();
        i_scia_scanner_model.do_commit(LIM + 5);
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic t_reset_and_empty();
        check("ctl after reset", ctl, 32'h0);
        i_scia_scanner_model.rd_in(4'h0, got);
        check("status before commit", {got.valid, got.err, got.rdata}, 32'h200);
        i_scia_scanner_model.clear_spare();
    endtask
    task automatic t_reset_start();
        wr(4'h1, 8'h20);
        wr(4'h0, 8'hC0);
        cmt();
        check("run trip mset", {ctl.run, ctl.trip_reset, ctl.motor_set}, 32'h7);
        settle(1);
        check("trip pulse end", ctl.trip_reset, 32'h0);
        wr(4'h0, 8'h80);
        cmt();
        check("stop held reset", {ctl.run, ctl.trip_reset}, 32'h0);
        settle(1);
        check("held reset ignored", ctl.trip_reset, 32'h0);
        wr(4'h1, 8'h00);
        wr(4'h0, 8'h40);
        cmt();
        check("start primary", {ctl.run, ctl.motor_set}, 32'h2);
    endtask
    task automatic t_resend();
        override_active = 1'h1;
        settle(2);
        check("run under override", {ctl.run, ctl.net_enabled}, 32'h0);
        override_active = 1'h0;
        settle(2);
        check("run resent", {ctl.run, ctl.net_enabled}, 32'h3);
        cmd_src_network = 1'h0;
        disable_active = 1'h1;
        settle(2);
        check("run off network", {ctl.run, ctl.net_enabled}, 32'h0);
        cmd_src_network = 1'h1;
        disable_active = 1'h0;
        settle(2);
        check("run back", ctl.run, 32'h1);
    endtask
    task automatic rd_all(input logic [95:0] exp);
        for (int i = 0; i < 12; i++) begin
            i_scia_scanner_model.rd_in(i[3:0], got);
            check("input byte", {got.valid, got.err, got.rdata}, {22'h0, 2'h2, exp[8*i+:8]});
        end
    endtask
    task automatic t_status();
        starter = '{1'h1, 1'h1, 1'h0, 1'h1, 1'h1, 1'h0, 1'h1, 1'h1, 1'h1,
                    32'h0001_0D42, 16'h0B1C};
        cmt();
        rd_all({16'h0000, 16'h0B1C, 32'h0001_0D42, 16'h0000, 16'h839B});
        // The complementary pattern catches status bits stuck at one that the first one hides; swapped bits equal in one pattern stay equal in both.
        starter = '{1'h0, 1'h0, 1'h1, 1'h0, 1'h0, 1'h1, 1'h0, 1'h0, 1'h0,
                    32'h0000_0D7A, 16'h0041};
        cmd_src_network = 1'h0;
        cmt();
        cmd_src_network = 1'h1;
        rd_all({16'h0000, 16'h0041, 32'h0000_0D7A, 16'h0000, 16'h0024});
    endtask
    task automatic t_refuse();
        logic [7:0] cl [5] = '{8'h05, 8'h04, 8'h04, 8'h04, 8'h04};
        logic [7:0] in [5] = '{8'h65, 8'h65, 8'h64, 8'h65, 8'h64};
        logic [3:0] ix [5] = '{4'h0, 4'hC, 4'h4, 4'h0, 4'h0};
        logic       w  [5] = '{1'h0, 1'h0, 1'h1, 1'h1, 1'h0};
        for (int i = 0; i < 5; i++) begin
            i_scia_scanner_model.xfer(w[i], cl[i], in[i], ix[i], 8'h00, got);
            check("refused", {got.valid, got.err, got.rdata}, 32'h300);
        end
        cmt();
        check("held command", {ctl.run, interval_fault}, 32'h2);
    endtask
    task automatic t_interval();
        i_scia_scanner_model.do_commit(3);
        settle(2);
        check("interval fault", interval_fault, 32'h1);
    endtask

    initial begin
        #(100 * 6000);
        n_fail++;
        end_sim();
    end
    initial begin
        repeat (3) @(posedge sys_clk);
        #1;
        rst_b = 1'h1;
        t_reset_and_empty();
        t_reset_start();
        t_resend();
        t_status();
        t_refuse();
        t_interval();
        end_sim();
    end
endmodule
